// file: logic/dac_corr_pkg.sv
/*
  Shared constants and types of the DAC code correction data path.
  Assumes a single clock domain and a host that writes through a
  plain word-wide write strobe.
*/
package dac_corr_pkg;

  // Channel organisation
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned CODE_W     = 16;
  localparam int unsigned CHAN_W     = 3;

  // Reset values
  localparam logic [15:0] GAIN_RST   = 16'h8000;
  localparam logic [15:0] ZERO_RST   = 16'h0000;
  localparam logic [15:0] INPUT_RST  = 16'h0000;
  localparam logic [15:0] DATA_RST   = 16'h0000;

  // Gain term bias (2^15) and result limits
  localparam logic [16:0] GAIN_BIAS  = 17'h08000;
  localparam logic [15:0] CODE_MAX   = 16'hffff;
  localparam logic [15:0] CODE_MIN   = 16'h0000;

  // Twos complement to straight binary: flip the sign bit
  localparam logic [15:0] SIGN_FLIP  = 16'h8000;

  // Nominal factory offset converter codes, straight binary
  localparam logic [15:0] TRIM_GAIN6 = 16'h999a;
  localparam logic [15:0] TRIM_GAIN4 = 16'haaab;

  // Register selected by a write or read
  typedef enum logic [1:0] {
    SEL_INPUT,
    SEL_GAIN,
    SEL_ZERO,
    SEL_OFFSET
  } reg_sel_e;

  // Host register access
  typedef struct packed {
    reg_sel_e              sel;
    logic [CHAN_W-1:0]     chan;
    logic [CODE_W-1:0]     data;
  } reg_req_s;

  // All eight latch codes
  typedef logic [NUM_CH-1:0][CODE_W-1:0] code_bank_t;

endpackage

// file: logic/dac_correction_engine.sv
/*
  Digital data path of an eight-channel 16-bit converter: input, gain,
  zero and data registers per channel, one shared correction engine,
  output latches and two group offset converter codes.
  Assumes all inputs are synchronous to MCLK and that the serial
  front end turns host frames into single-cycle write and read strobes.
*/
`timescale 1ns/1ps
module dac_correction_engine #(
  parameter logic [15:0] TRIM_A_GAIN6 = dac_corr_pkg::TRIM_GAIN6,
  parameter logic [15:0] TRIM_A_GAIN4 = dac_corr_pkg::TRIM_GAIN4,
  parameter logic [15:0] TRIM_B_GAIN6 = dac_corr_pkg::TRIM_GAIN6,
  parameter logic [15:0] TRIM_B_GAIN4 = dac_corr_pkg::TRIM_GAIN4
) (
  // Clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     SYS_RST,
  // Register write strobe
  input  wire logic                     WR_VALID,
  input  wire dac_corr_pkg::reg_req_s   WR_REQ,
  // Register read strobe and answer
  input  wire logic                     RD_VALID,
  input  wire dac_corr_pkg::reg_req_s   RD_REQ,
  output logic [15:0]                   RD_DATA,
  output logic                          RD_DONE,
  // Configuration
  input  wire logic                     CORRECTION_ENABLE,
  input  wire logic                     GAIN_SELECT,
  input  wire logic                     FORMAT_SELECT,
  input  wire logic                     DUAL_SUPPLY,
  // Output control
  input  wire logic                     LATCH_LOAD,
  input  wire logic                     OUTPUT_CLEAR,
  // Converter side
  output dac_corr_pkg::code_bank_t      LATCH_CODE,
  output logic                          OUTPUTS_CLEARED,
  output logic                          AMP_GAIN_SIX,
  output logic [15:0]                   OFFSET_CODE_A,
  output logic [15:0]                   OFFSET_CODE_B,
  output logic                          OFFSET_PWRDN,
  output logic                          BUSY
);

  typedef enum logic {ENG_IDLE, ENG_CALC} eng_state_e;

  localparam int unsigned N = dac_corr_pkg::NUM_CH;

  logic [N-1:0][15:0]  input_q;
  logic [N-1:0][15:0]  gain_q;
  logic [N-1:0][15:0]  zero_q;
  logic [N-1:0][15:0]  data_q;
  logic [N-1:0]        pend_q;
  logic [N-1:0]        pend_d;
  logic [N-1:0]        wr_hit;
  logic [2:0]          eng_chan_q;
  logic [2:0]          pick;
  logic                pick_ok;
  eng_state_e          state_q;
  logic                init_q;
  logic                gsel_q;
  logic [15:0]         fmt_mask;
  logic [15:0]         wr_bin;
  logic [15:0]         in_bin;
  logic [33:0]         prod;
  logic signed [18:0]  sum;
  logic [15:0]         corr;
  logic                calc_now;

  // Twos complement codes differ from binary only in the sign bit
  assign fmt_mask = FORMAT_SELECT ? dac_corr_pkg::SIGN_FLIP : 16'h0000;
  assign wr_bin   = WR_REQ.data ^ fmt_mask;

  // Channels whose correction a write in this cycle requests
  always_comb begin
    wr_hit = '0;
    if (WR_VALID && CORRECTION_ENABLE && WR_REQ.sel != dac_corr_pkg::SEL_OFFSET) begin
      wr_hit[WR_REQ.chan] = 1'b1;
    end
  end

  // Lowest pending channel wins; fairness is not needed as each takes two cycles
  always_comb begin
    pick    = 3'h0;
    pick_ok = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        pick    = 3'(i);
        pick_ok = 1'b1;
      end
    end
  end

  assign calc_now = (state_q == ENG_CALC) && CORRECTION_ENABLE;

  // Corrected code from the latched channel, saturated to 16 bits
  always_comb begin
    in_bin = input_q[eng_chan_q] ^ fmt_mask;
    prod   = in_bin * (17'(gain_q[eng_chan_q]) + dac_corr_pkg::GAIN_BIAS);
    sum    = $signed({1'b0, prod[33:16]}) + 19'($signed(zero_q[eng_chan_q]));
    if (sum < 0) begin
      corr = dac_corr_pkg::CODE_MIN;
    end else if (sum > $signed({3'b000, dac_corr_pkg::CODE_MAX})) begin
      corr = dac_corr_pkg::CODE_MAX;
    end else begin
      corr = sum[15:0];
    end
  end

  // Pending set wins over the clear of the channel just taken
  always_comb begin
    pend_d = pend_q;
    if (!CORRECTION_ENABLE) begin
      pend_d = '0;
    end else if (state_q == ENG_IDLE && pick_ok) begin
      pend_d[pick] = 1'b0;
    end
    pend_d = pend_d | wr_hit;
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Single shared engine, one channel per pass
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q    <= ENG_IDLE;
      eng_chan_q <= 3'h0;
    end else begin
      unique case (state_q)
        ENG_IDLE: begin
          if (pick_ok && CORRECTION_ENABLE) begin
            state_q    <= ENG_CALC;
            eng_chan_q <= pick;
          end
        end
        ENG_CALC: begin
          state_q <= ENG_IDLE;
        end
      endcase
    end
  end

  // Host-written registers kept exactly as written for read-back
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < N; i++) begin
        input_q[i] <= dac_corr_pkg::INPUT_RST;
        gain_q[i]  <= dac_corr_pkg::GAIN_RST;
        zero_q[i]  <= dac_corr_pkg::ZERO_RST;
      end
    end else if (WR_VALID) begin
      unique case (WR_REQ.sel)
        dac_corr_pkg::SEL_INPUT:  input_q[WR_REQ.chan] <= WR_REQ.data;
        dac_corr_pkg::SEL_GAIN:   gain_q[WR_REQ.chan]  <= WR_REQ.data;
        dac_corr_pkg::SEL_ZERO:   zero_q[WR_REQ.chan]  <= WR_REQ.data;
        dac_corr_pkg::SEL_OFFSET: ;
      endcase
    end
  end

  // Data registers: direct input when disabled, engine result when enabled
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < N; i++) begin
        data_q[i] <= dac_corr_pkg::DATA_RST;
      end
    end else begin
      if (calc_now) begin
        data_q[eng_chan_q] <= corr;
      end
      if (WR_VALID && !CORRECTION_ENABLE && WR_REQ.sel == dac_corr_pkg::SEL_INPUT) begin
        data_q[WR_REQ.chan] <= wr_bin;
      end
    end
  end

  // Latches follow the load strobe; loads are ignored while clear is held
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < N; i++) begin
        LATCH_CODE[i] <= dac_corr_pkg::DATA_RST;
      end
      OUTPUTS_CLEARED <= 1'b0;
    end else begin
      if (OUTPUT_CLEAR) begin
        OUTPUTS_CLEARED <= 1'b1;
      end else if (LATCH_LOAD) begin
        LATCH_CODE      <= data_q;
        OUTPUTS_CLEARED <= 1'b0;
      end
    end
  end

  // Offset codes: defaults at reset release and on each gain change
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      init_q        <= 1'b1;
      gsel_q        <= 1'b0;
      OFFSET_CODE_A <= dac_corr_pkg::TRIM_GAIN6;
      OFFSET_CODE_B <= dac_corr_pkg::TRIM_GAIN6;
    end else begin
      init_q <= 1'b0;
      gsel_q <= GAIN_SELECT;
      if (init_q || GAIN_SELECT != gsel_q) begin
        OFFSET_CODE_A <= GAIN_SELECT ? TRIM_A_GAIN6 : TRIM_A_GAIN4;
        OFFSET_CODE_B <= GAIN_SELECT ? TRIM_B_GAIN6 : TRIM_B_GAIN4;
      end else if (WR_VALID && WR_REQ.sel == dac_corr_pkg::SEL_OFFSET) begin
        if (WR_REQ.chan[2]) begin
          OFFSET_CODE_B <= wr_bin;
        end else begin
          OFFSET_CODE_A <= wr_bin;
        end
      end
    end
  end

  // Analog controls and engine activity
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      AMP_GAIN_SIX <= 1'b1;
      OFFSET_PWRDN <= 1'b1;
      BUSY         <= 1'b0;
    end else begin
      AMP_GAIN_SIX <= GAIN_SELECT;
      OFFSET_PWRDN <= !DUAL_SUPPLY;
      BUSY         <= (pend_d != '0) || (state_q == ENG_IDLE && pick_ok && CORRECTION_ENABLE);
    end
  end

  // Read-back of input, gain and zero as written; offset codes in the current format
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_DATA <= 16'h0000;
      RD_DONE <= 1'b0;
    end else begin
      RD_DONE <= RD_VALID;
      if (RD_VALID) begin
        unique case (RD_REQ.sel)
          dac_corr_pkg::SEL_INPUT:  RD_DATA <= input_q[RD_REQ.chan];
          dac_corr_pkg::SEL_GAIN:   RD_DATA <= gain_q[RD_REQ.chan];
          dac_corr_pkg::SEL_ZERO:   RD_DATA <= zero_q[RD_REQ.chan];
          dac_corr_pkg::SEL_OFFSET: RD_DATA <= (RD_REQ.chan[2] ? OFFSET_CODE_B : OFFSET_CODE_A) ^ fmt_mask;
        endcase
      end
    end
  end

  // Independent reference of the corrected code for checking
  longint ref_val;
  always_comb begin
    ref_val = (longint'(input_q[eng_chan_q] ^ fmt_mask) * (longint'(gain_q[eng_chan_q]) + 32768)) / 65536
              + longint'($signed(zero_q[eng_chan_q]));
    if (ref_val < 0) begin
      ref_val = 0;
    end
    if (ref_val > 65535) begin
      ref_val = 65535;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  corr_result_a: assert property (calc_now |=> data_q[$past(eng_chan_q)] == 16'($past(ref_val)))
    else $error("corrected code wrong");
  direct_load_a: assert property (WR_VALID && !CORRECTION_ENABLE && WR_REQ.sel == dac_corr_pkg::SEL_INPUT
                                  |=> data_q[$past(WR_REQ.chan)] == ($past(WR_REQ.data) ^ $past(fmt_mask)))
    else $error("direct input not loaded");
  write_starts_a: assert property (WR_VALID && CORRECTION_ENABLE && WR_REQ.sel != dac_corr_pkg::SEL_OFFSET
                                   ##1 CORRECTION_ENABLE |-> pend_q[$past(WR_REQ.chan)] || state_q == ENG_CALC)
    else $error("write did not request correction");
  one_engine_a: assert property (state_q == ENG_CALC |=> state_q == ENG_IDLE)
    else $error("engine held two passes");
  reset_vals_a: assert property ($past(SYS_RST) |-> gain_q[3] == 16'h8000 && zero_q[5] == 16'h0000
                                 && input_q[0] == 16'h0000)
    else $error("reset values wrong");
  offset_reload_a: assert property (GAIN_SELECT != gsel_q
                                    |=> OFFSET_CODE_A == ($past(GAIN_SELECT) ? TRIM_A_GAIN6 : TRIM_A_GAIN4)
                                        && OFFSET_CODE_B == ($past(GAIN_SELECT) ? TRIM_B_GAIN6 : TRIM_B_GAIN4))
    else $error("offset defaults not reloaded");
  offset_pwrdn_a: assert property (!DUAL_SUPPLY ##1 !DUAL_SUPPLY |-> OFFSET_PWRDN)
    else $error("offset converters not powered down");
  clear_hold_a: assert property (OUTPUT_CLEAR |=> $stable(LATCH_CODE) && OUTPUTS_CLEARED)
    else $error("clear changed latches");
  gain_read_a: assert property (WR_VALID && WR_REQ.sel == dac_corr_pkg::SEL_GAIN ##1 !WR_VALID ##1
                                RD_VALID && RD_REQ.sel == dac_corr_pkg::SEL_GAIN
                                && RD_REQ.chan == $past(WR_REQ.chan, 2)
                                |=> RD_DATA == $past(WR_REQ.data, 3))
    else $error("gain read-back differs");

  corr_pass_c:   cover property (calc_now ##1 LATCH_LOAD);
  direct_path_c: cover property (WR_VALID && !CORRECTION_ENABLE ##1 LATCH_LOAD);
  reload_c:      cover property (GAIN_SELECT != gsel_q);
  clear_c:       cover property (OUTPUT_CLEAR ##1 !OUTPUT_CLEAR ##1 LATCH_LOAD);

endmodule  // dac_correction_engine

// file: verification/dac_host_model.sv
/*
  Host side model: issues single-cycle register writes and reads.
  Assumes the bench calls its tasks and that the engine samples on rising MCLK.
*/
`timescale 1ns/1ps
module dac_host_model (
  // Clock
  input  wire logic                   mclk,
  // Write strobe
  output logic                        wr_valid,
  output dac_corr_pkg::reg_req_s      wr_req,
  // Read strobe and answer
  output logic                        rd_valid,
  output dac_corr_pkg::reg_req_s      rd_req,
  input  wire logic [15:0]            rd_data,
  input  wire logic                   rd_done
);
  // Idle strobes from time zero
  initial begin
    wr_valid = 1'b0;
    wr_req   = '0;
    rd_valid = 1'b0;
    rd_req   = '0;
  end

  // One word a write; data inverted once released so stale values never match
  task automatic write_reg(input dac_corr_pkg::reg_sel_e sel, input logic [2:0] chan, input logic [15:0] data);
    @(negedge mclk);
    wr_req.sel  = sel;
    wr_req.chan = chan;
    wr_req.data = data;
    wr_valid    = 1'b1;
    @(negedge mclk);
    wr_valid    = 1'b0;
    wr_req.data = ~data;
  endtask

  // Answer taken at the falling edge after the taking edge, while RD_DONE stands
  task automatic read_reg(input dac_corr_pkg::reg_sel_e sel, input logic [2:0] chan, output logic [15:0] data,
                          output logic ok);
    @(negedge mclk);
    rd_req.sel  = sel;
    rd_req.chan = chan;
    rd_valid    = 1'b1;
    @(negedge mclk);
    ok          = rd_done;
    data        = rd_data;
    rd_valid    = 1'b0;
  endtask
endmodule // dac_host_model

// file: verification/dac_code_correction_engine_tb_top.sv
/*
  Self-checking bench of the correction data path against an integer model.
  Assumes the host model drives all register traffic.
*/
`timescale 1ns/1ps
module dac_code_correction_engine_tb_top;
  logic        mclk = 1'b0, sys_rst = 1'b1, corr_en = 1'b0, gain_sel = 1'b1, fmt_sel = 1'b0;
  logic        dual = 1'b1, latch_load = 1'b0, out_clear = 1'b0;
  logic        wr_valid, rd_valid, rd_done, cleared, amp6, pwrdn, busy;
  logic [15:0] rd_data, off_a, off_b;
  dac_corr_pkg::reg_req_s   wr_req, rd_req;
  dac_corr_pkg::code_bank_t latch;
  int          err_count = 0, compares = 0, seed = 82237;
  int          gain_m[8], zero_m[8], inp_m[8], data_m[8], lat_m[8];

  // 50 MHz clock
  always #10 mclk = ~mclk;

  dac_correction_engine i_dac_correction_engine (
    .MCLK(mclk), .SYS_RST(sys_rst), .WR_VALID(wr_valid), .WR_REQ(wr_req), .RD_VALID(rd_valid),
    .RD_REQ(rd_req), .RD_DATA(rd_data), .RD_DONE(rd_done), .CORRECTION_ENABLE(corr_en),
    .GAIN_SELECT(gain_sel), .FORMAT_SELECT(fmt_sel), .DUAL_SUPPLY(dual), .LATCH_LOAD(latch_load),
    .OUTPUT_CLEAR(out_clear), .LATCH_CODE(latch), .OUTPUTS_CLEARED(cleared), .AMP_GAIN_SIX(amp6),
    .OFFSET_CODE_A(off_a), .OFFSET_CODE_B(off_b), .OFFSET_PWRDN(pwrdn), .BUSY(busy));

  dac_host_model i_dac_host_model (
    .mclk(mclk), .wr_valid(wr_valid), .wr_req(wr_req), .rd_valid(rd_valid), .rd_req(rd_req),
    .rd_data(rd_data), .rd_done(rd_done));

  // Compare tasks
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // Reference correction; longint since the product needs 33 bits
  function automatic int calc(int ch);
    longint b, r;
    b = fmt_sel ? (inp_m[ch] ^ 32'h8000) : inp_m[ch];
    if (!corr_en) return int'(b);
    r = b * (gain_m[ch] + 32768) / 65536 + (zero_m[ch] >= 32768 ? zero_m[ch] - 65536 : zero_m[ch]);
    return r < 0 ? 0 : (r > 65535 ? 65535 : int'(r));
  endfunction

  // Write through the host and track the model
  task automatic wr(input dac_corr_pkg::reg_sel_e sel, input int ch, input int val);
    i_dac_host_model.write_reg(sel, ch[2:0], val[15:0]);
    if (sel == dac_corr_pkg::SEL_INPUT) inp_m[ch] = val & 'hffff;
    if (sel == dac_corr_pkg::SEL_GAIN) gain_m[ch] = val & 'hffff;
    if (sel == dac_corr_pkg::SEL_ZERO) zero_m[ch] = val & 'hffff;
    if (sel == dac_corr_pkg::SEL_INPUT || (corr_en && sel != dac_corr_pkg::SEL_OFFSET)) data_m[ch] = calc(ch);
  endtask

  task automatic rd(input dac_corr_pkg::reg_sel_e sel, input int ch, input int exp);
    logic [15:0] d;
    logic        ok;
    i_dac_host_model.read_reg(sel, ch[2:0], d, ok);
    chk_flag(ok, 1'b1);
    chk_word(d, exp[15:0]);
  endtask

  // Drain the engine, pulse the load, compare all eight latches
  task automatic latch_check();
    int n;
    repeat (3) @(negedge mclk);
    for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge mclk);
    chk_flag(busy, 1'b0);
    latch_load = 1'b1;
    @(negedge mclk);
    latch_load = 1'b0;
    @(negedge mclk);
    if (!out_clear) lat_m = data_m;
    for (int c = 0; c < 8; c++) chk_word(latch[c], lat_m[c][15:0]);
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well past the expected few hundred cycles
  initial begin
    #200000;
    err_count++;
    close_out();
  end

  // Extreme gain, zero and input codes for the saturation corners on channels 0 and 1, unity and half gain on 2 and 3
  int edge_in[4] = '{'hffff, 'h0000, 'h8000, 'hffff};
  int edge_g[4]  = '{'hffff, 'h0000, 'h8000, 'h0000};
  int edge_z[4]  = '{'h7fff, 'h8000, 'h0000, 'h0000};

  // Main sequence
  initial begin
    for (int c = 0; c < 8; c++) begin
      gain_m[c] = 32768;
      zero_m[c] = 0;
      inp_m[c]  = 0;
      data_m[c] = 0;
      lat_m[c]  = 0;
    end
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk_word(off_a, dac_corr_pkg::TRIM_GAIN6);
    chk_word(off_b, dac_corr_pkg::TRIM_GAIN6);
    chk_flag(amp6, 1'b1);
    chk_flag(pwrdn, 1'b0);
    for (int c = 0; c < 8; c++) begin
      rd(dac_corr_pkg::SEL_GAIN, c, 'h8000);
      rd(dac_corr_pkg::SEL_ZERO, c, 0);
      rd(dac_corr_pkg::SEL_INPUT, c, 0);
    end
    // Bypass: input goes straight through, gain writes only stored
    for (int c = 0; c < 8; c++) begin
      wr(dac_corr_pkg::SEL_INPUT, c, $random(seed));
      wr(dac_corr_pkg::SEL_GAIN, c, $random(seed));
    end
    latch_check();
    for (int c = 0; c < 8; c++) rd(dac_corr_pkg::SEL_GAIN, c, gain_m[c]);
    wr(dac_corr_pkg::SEL_GAIN, 5, $random(seed));
    rd(dac_corr_pkg::SEL_GAIN, 5, gain_m[5]);
    // Engine on: corners then random, back to back across channels
    corr_en = 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(dac_corr_pkg::SEL_INPUT, c, c < 4 ? edge_in[c] : $random(seed));
      wr(dac_corr_pkg::SEL_GAIN, c, c < 4 ? edge_g[c] : $random(seed));
      wr(dac_corr_pkg::SEL_ZERO, c, c < 4 ? edge_z[c] : $random(seed));
    end
    latch_check();
    for (int c = 0; c < 8; c++) rd(dac_corr_pkg::SEL_ZERO, c, zero_m[c]);
    // Clear holds latches and ignores loads
    out_clear = 1'b1;
    wr(dac_corr_pkg::SEL_INPUT, 1, $random(seed));
    latch_check();
    chk_flag(cleared, 1'b1);
    out_clear = 1'b0;
    latch_check();
    chk_flag(cleared, 1'b0);
    // Twos complement inputs and offsets
    fmt_sel = 1'b1;
    for (int c = 0; c < 8; c++) wr(dac_corr_pkg::SEL_INPUT, c, $random(seed));
    latch_check();
    for (int c = 0; c < 8; c++) rd(dac_corr_pkg::SEL_INPUT, c, inp_m[c]);
    wr(dac_corr_pkg::SEL_OFFSET, 0, 'h1234);
    wr(dac_corr_pkg::SEL_OFFSET, 4, 'hc321);
    @(negedge mclk);
    chk_word(off_a, 16'h9234);
    chk_word(off_b, 16'h4321);
    rd(dac_corr_pkg::SEL_OFFSET, 4, 'hc321);
    // Gain four reloads both offsets
    gain_sel = 1'b0;
    repeat (2) @(negedge mclk);
    chk_word(off_a, dac_corr_pkg::TRIM_GAIN4);
    chk_word(off_b, dac_corr_pkg::TRIM_GAIN4);
    chk_flag(amp6, 1'b0);
    dual = 1'b0;
    repeat (2) @(negedge mclk);
    chk_flag(pwrdn, 1'b1);
    close_out();
  end
endmodule // dac_code_correction_engine_tb_top
